/* File: hw/epi_pkg.sv */
// Constants for the external pin interrupt unit.
// Assumes a 20 MHz system clock and AHB-Lite register access.
// What this block does
// R1: Pin activity requests even when driven as output.
// R2: Inputs 0/1 level or edge; input 2 edge.
// R3: Enabled low level requests while pin stays low.
// R4: Edge sensing on inputs 0/1 needs I/O clock.
// R5: Low level and input-2 edges need no clock.
// R6: Power-down level wake: two watchdog samples, startup.
// R7: Level gone before startup end: wake, no request.
// R8: Request needs global and per-input enable bits.
// R9: Input 1 sense field bits 3:2, four codes.
// R10: Input 0 sense field bits 1:0, same codes.
// R11: Pins sampled before edges; longer pulses guaranteed.
// R12: Source holds low level until instruction completes.
// R13: Input 2 polarity bit 6: falling or rising.
// R14: Software disables input 2 before changing polarity.
// R15: Each input has its own request vector.
// R16: Trigger sets flag bits 7, 6 and 5.
// R17: Flag clears on vector service or written one.
// R18: Level mode holds the flag cleared.
// R19: Sleep with input 2 disabled may set flag.
// R20: Inputs 0/1 pass a two-stage synchroniser.
package epi_pkg;
    localparam int CLK_PERIOD_NS = 50;
    localparam int STARTUP_NS = 4000;
    localparam int STARTUP_CYC = (STARTUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [11:0] OFS_CPU_CONTROL = 12'h000;
    localparam logic [11:0] OFS_CPU_CONTROL_STATUS = 12'h004;
    localparam logic [11:0] OFS_EXT_IRQ_ENABLE = 12'h008;
    localparam logic [11:0] OFS_EXT_IRQ_FLAGS = 12'h00C;
    localparam int POS_SENSE_ONE = 2;
    localparam int POS_SENSE_ZERO = 0;
    localparam int POS_SENSE_TWO = 6;
    localparam int POS_EN_ONE = 7;
    localparam int POS_EN_ZERO = 6;
    localparam int POS_EN_TWO = 5;
    localparam int POS_FLAG_ONE = 7;
    localparam int POS_FLAG_ZERO = 6;
    localparam int POS_FLAG_TWO = 5;
    localparam logic [1:0] RST_SENSE = 2'h0;
    localparam logic [2:0] RST_ENABLE = 3'h0;
    localparam logic [2:0] RST_FLAGS = 3'h0;
    localparam logic [2:0] RST_PINS = 3'h7;
    localparam logic [1:0] SENSE_LOW = 2'h0;
    localparam logic [1:0] SENSE_ANY = 2'h1;
    localparam logic [1:0] SENSE_FALL = 2'h2;
    localparam logic [1:0] SENSE_RISE = 2'h3;
    typedef enum logic [1:0] {ST_RUN, ST_SLEEP, ST_SEEN1, ST_STARTUP} epi_pwr_t;
endpackage : epi_pkg

/* File: hw/epi_ext_irq.sv */
// External pin interrupt unit: three request pins, flags, enables, wake-up.
// Assumes one 20 MHz clock, an AHB-Lite master, and a core that acks vectors.
`timescale 1ns/100ps
module epi_ext_irq #(
    parameter int STARTUP_CYCLES = epi_pkg::STARTUP_CYC
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    input wire logic ext_request_zero_i,
    input wire logic ext_request_one_i,
    input wire logic ext_request_two_i,
    input wire logic global_ie_i,
    input wire logic io_clk_run_i,
    input wire logic power_down_i,
    input wire logic wdt_tick_i,
    input wire logic [2:0] vector_ack_i,
    output logic [2:0] irq_req_o,
    output logic wake_o,
    output logic asleep_o
);
    import epi_pkg::*;

    logic [2:0] sync1;
    logic [2:0] sync2;
    logic [2:0] prev;
    logic [2:0] eff;
    logic [2:0] en;
    logic [2:0] flag;
    logic [2:0] lvl_mode;
    logic [2:0] level_on;
    logic [2:0] hit;
    logic [2:0] w1c;
    logic [1:0] sense_zero;
    logic [1:0] sense_one;
    logic sense_two_polarity;
    logic awake;
    logic buf_off;
    epi_pwr_t state;
    logic [15:0] su_cnt;
    logic aphase;
    logic wr_pend;
    logic [11:0] wr_addr;
    logic rd_late;
    logic [11:0] rd_addr;

    ////////////////////////////////////////////////////////////////////////
    // Pin sampling
    ////////////////////////////////////////////////////////////////////////

    // Pins are sensed whatever the port direction, so driving them works
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            sync1 <= RST_PINS;
            sync2 <= RST_PINS;
            prev <= RST_PINS;
        end else begin
            sync1 <= {ext_request_two_i, ext_request_one_i, ext_request_zero_i}; // R1
            sync2 <= sync1; // R20
            prev <= eff; // R11
        end
    end

    function automatic logic edge_hit(input logic [1:0] mode, input logic now, input logic was);
        case (mode)
            SENSE_ANY: edge_hit = now ^ was;
            SENSE_FALL: edge_hit = was & ~now;
            SENSE_RISE: edge_hit = now & ~was;
            default: edge_hit = 1'b0;
        endcase
    endfunction : edge_hit

    always_comb begin
        awake = (state == ST_RUN);
        // Input buffer of pin 2 is cut while asleep and disabled
        buf_off = !awake && !en[2]; // R19
        eff = {sync2[2] & ~buf_off, sync2[1:0]};
        lvl_mode = {1'b0, sense_one == SENSE_LOW, sense_zero == SENSE_LOW}; // R2
        // Level sensing is clockless, so it stays live in every state
        level_on = lvl_mode & ~eff & en; // R5
        hit[0] = io_clk_run_i && edge_hit(sense_zero, eff[0], prev[0]); // R4 R10
        hit[1] = io_clk_run_i && edge_hit(sense_one, eff[1], prev[1]); // R4 R9
        // Input 2 never waits on the I/O clock
        hit[2] = sense_two_polarity ? (eff[2] & ~prev[2]) : (prev[2] & ~eff[2]); // R13 R5
    end

    ////////////////////////////////////////////////////////////////////////
    // Flags
    ////////////////////////////////////////////////////////////////////////

    always_comb begin
        w1c = 3'h0;
        if (wr_pend && wr_addr == OFS_EXT_IRQ_FLAGS) begin
            w1c = {hwdata_i[POS_FLAG_TWO], hwdata_i[POS_FLAG_ONE], hwdata_i[POS_FLAG_ZERO]};
        end
    end

    // A new event beats a clear landing in the same cycle
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            flag <= RST_FLAGS;
        end else begin
            for (int k = 0; k < 3; k++) begin
                if (lvl_mode[k]) begin
                    flag[k] <= 1'b0; // R18
                end else if (hit[k]) begin
                    flag[k] <= 1'b1; // R16
                end else if (w1c[k] || vector_ack_i[k]) begin
                    flag[k] <= 1'b0; // R17
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Requests, one line per vector
    ////////////////////////////////////////////////////////////////////////

    // Level requests wait for full wake, so a vanished level is dropped
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            irq_req_o <= 3'h0;
        end else begin
            for (int k = 0; k < 3; k++) begin
                irq_req_o[k] <= global_ie_i && en[k] && awake && (flag[k] || level_on[k]); // R8 R3 R15 R7
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Power-down wake sequencing
    ////////////////////////////////////////////////////////////////////////

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            state <= ST_RUN;
            su_cnt <= 16'h0000;
            wake_o <= 1'b0;
            asleep_o <= 1'b0;
        end else begin
            wake_o <= 1'b0;
            asleep_o <= !awake;
            case (state)
                ST_RUN: begin
                    if (power_down_i) begin
                        state <= ST_SLEEP;
                    end
                end
                ST_SLEEP: begin
                    if (hit[2] && en[2]) begin
                        state <= ST_STARTUP; // R5
                        su_cnt <= 16'(STARTUP_CYCLES);
                    end else if (wdt_tick_i && |level_on) begin
                        state <= ST_SEEN1; // R6
                    end
                end
                ST_SEEN1: begin
                    // Second watchdog sample must still see the level
                    if (wdt_tick_i) begin
                        if (|level_on) begin
                            state <= ST_STARTUP; // R6
                            su_cnt <= 16'(STARTUP_CYCLES);
                        end else begin
                            state <= ST_SLEEP;
                        end
                    end
                end
                ST_STARTUP: begin
                    if (su_cnt <= 16'h0001) begin
                        state <= ST_RUN; // R7
                        wake_o <= 1'b1;
                    end else begin
                        su_cnt <= su_cnt - 16'h0001;
                    end
                end
                default: begin
                    state <= ST_RUN;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // AHB-Lite slave
    ////////////////////////////////////////////////////////////////////////

    function automatic logic [7:0] rd_byte(input logic [11:0] a);
        rd_byte = 8'h00;
        case (a)
            OFS_CPU_CONTROL: begin
                rd_byte[POS_SENSE_ONE +: 2] = sense_one;
                rd_byte[POS_SENSE_ZERO +: 2] = sense_zero;
            end
            OFS_CPU_CONTROL_STATUS: rd_byte[POS_SENSE_TWO] = sense_two_polarity;
            OFS_EXT_IRQ_ENABLE: begin
                rd_byte[POS_EN_ONE] = en[1];
                rd_byte[POS_EN_ZERO] = en[0];
                rd_byte[POS_EN_TWO] = en[2];
            end
            OFS_EXT_IRQ_FLAGS: begin
                rd_byte[POS_FLAG_ONE] = flag[1];
                rd_byte[POS_FLAG_ZERO] = flag[0];
                rd_byte[POS_FLAG_TWO] = flag[2];
            end
            default: rd_byte = 8'h00;
        endcase
    endfunction : rd_byte

    assign aphase = hsel_i && hready_i && htrans_i[1];

    // A read right behind a write waits one cycle to see the new value
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            wr_pend <= 1'b0;
            wr_addr <= 12'h000;
            rd_late <= 1'b0;
            rd_addr <= 12'h000;
            hrdata_o <= 32'h0000_0000;
            hreadyout_o <= 1'b1;
            hresp_o <= 1'b0;
        end else begin
            wr_pend <= aphase && hwrite_i;
            wr_addr <= haddr_i[11:0];
            rd_late <= aphase && !hwrite_i && wr_pend;
            rd_addr <= haddr_i[11:0];
            hreadyout_o <= !(aphase && !hwrite_i && wr_pend);
            hresp_o <= 1'b0;
            if (aphase && !hwrite_i) begin
                hrdata_o <= {24'h00_0000, rd_byte(haddr_i[11:0])};
            end else if (rd_late) begin
                hrdata_o <= {24'h00_0000, rd_byte(rd_addr)};
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            sense_one <= RST_SENSE;
            sense_zero <= RST_SENSE;
            sense_two_polarity <= 1'b0;
            en <= RST_ENABLE;
        end else if (wr_pend) begin
            case (wr_addr)
                OFS_CPU_CONTROL: begin
                    sense_one <= hwdata_i[POS_SENSE_ONE +: 2]; // R9
                    sense_zero <= hwdata_i[POS_SENSE_ZERO +: 2]; // R10
                end
                OFS_CPU_CONTROL_STATUS: sense_two_polarity <= hwdata_i[POS_SENSE_TWO]; // R13
                OFS_EXT_IRQ_ENABLE: begin
                    en <= {hwdata_i[POS_EN_TWO], hwdata_i[POS_EN_ONE], hwdata_i[POS_EN_ZERO]}; // R8
                end
                default: begin
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    ////////////////////////////////////////////////////////////////////////

    AST_LEVEL_HOLD: assert property (@(posedge clk_i) disable iff (srst_i) // R3
        (awake && global_ie_i && level_on[0]) |=> irq_req_o[0])
        else $error("level low did not request");

    AST_LEVEL_FLAG_CLR: assert property (@(posedge clk_i) disable iff (srst_i) // R18
        lvl_mode[1] |=> !flag[1])
        else $error("flag set in level mode");

    AST_NO_IO_EDGE: assert property (@(posedge clk_i) disable iff (srst_i) // R4
        (!io_clk_run_i && !flag[0] && !vector_ack_i[0]) |=> !flag[0])
        else $error("edge seen without io clock");

    AST_RISE_ZERO: assert property (@(posedge clk_i) disable iff (srst_i) // R10
        (io_clk_run_i && sense_zero == SENSE_RISE && eff[0] && !prev[0]) |=> flag[0])
        else $error("rising edge missed on input 0");

    AST_FALL_ONE: assert property (@(posedge clk_i) disable iff (srst_i) // R9
        (io_clk_run_i && sense_one == SENSE_FALL && !eff[1] && prev[1]) |=> flag[1])
        else $error("falling edge missed on input 1");

    AST_GATE: assert property (@(posedge clk_i) disable iff (srst_i) // R8
        !global_ie_i |=> irq_req_o == 3'h0)
        else $error("request without global enable");

    AST_W1C: assert property (@(posedge clk_i) disable iff (srst_i) // R17
        (wr_pend && wr_addr == OFS_EXT_IRQ_FLAGS && hwdata_i[POS_FLAG_TWO] && !hit[2]) |=> !flag[2])
        else $error("written one did not clear flag");

    AST_TWO_FALL: assert property (@(posedge clk_i) disable iff (srst_i) // R13
        (!sense_two_polarity && prev[2] && !eff[2]) |=> flag[2])
        else $error("input 2 falling edge missed");

    AST_SECOND_SAMPLE: assert property (@(posedge clk_i) disable iff (srst_i) // R6
        (state == ST_SEEN1 && wdt_tick_i && |level_on) |=> state == ST_STARTUP)
        else $error("second sample did not start wake");

    AST_ASLEEP_QUIET: assert property (@(posedge clk_i) disable iff (srst_i) // R7
        (state != ST_RUN) |=> irq_req_o == 3'h0)
        else $error("request before start-up ended");

    AST_STARTUP_HOLD: assert property (@(posedge clk_i) disable iff (srst_i) // R6
        $rose(state == ST_STARTUP) |-> (state == ST_STARTUP)[*8])
        else $error("start-up cut short");

    AST_ANY_ONE: assert property (@(posedge clk_i) disable iff (srst_i) // R9
        (io_clk_run_i && sense_one == SENSE_ANY && (eff[1] != prev[1])) |=> flag[1])
        else $error("any change missed on input 1");

    AST_ACK_CLR: assert property (@(posedge clk_i) disable iff (srst_i) // R17
        (vector_ack_i[1] && !hit[1]) |=> !flag[1])
        else $error("vector service did not clear flag");

    AST_TWO_SET: assert property (@(posedge clk_i) disable iff (srst_i) // R16
        hit[2] |=> flag[2])
        else $error("input 2 event did not set flag");

    AST_EN_GATE: assert property (@(posedge clk_i) disable iff (srst_i) // R8
        !en[1] |=> !irq_req_o[1])
        else $error("request from disabled input");

    AST_LEVEL_DROP: assert property (@(posedge clk_i) disable iff (srst_i) // R3
        (!level_on[0] && !flag[0]) |=> !irq_req_o[0])
        else $error("request after level released");

    AST_WAKE_END: assert property (@(posedge clk_i) disable iff (srst_i) // R7
        (state == ST_STARTUP && su_cnt <= 16'h0001) |=> (wake_o && state == ST_RUN))
        else $error("start-up did not end in wake");

    AST_SYNC_TWO: assert property (@(posedge clk_i) disable iff (srst_i) // R20
        !$past(srst_i) |-> sync2 == $past(sync1))
        else $error("pin synchroniser depth wrong");

endmodule : epi_ext_irq

/* File: sim/epi_pin_src.sv */
// Model of the sources driving the three external request pins.
// Assumes the bench calls its tasks; pins idle high like pulled-up lines.
`timescale 1ns/100ps
module epi_pin_src (
    input wire logic clk_i,
    output logic [2:0] pin_o
);
    initial pin_o = 3'h7;
    task automatic set_pin(input int k, input logic v);
        @(posedge clk_i);
        pin_o[k] <= v;
    endtask : set_pin
    // Low held well past any instruction in flight, else no request is sure
    task automatic hold_low(input int k, input int n);
        set_pin(k, 1'b0);
        repeat (n) @(posedge clk_i);
        pin_o[k] <= 1'b1;
    endtask : hold_low
endmodule : epi_pin_src

/* File: sim/tb_top.sv */
// Self-checking bench for the external pin interrupt unit.
// Assumes AHB-Lite single word transfers and a short start-up count.
`timescale 1ns/100ps
module tb_top;
    import epi_pkg::*;
    localparam int SU = 10;
    logic clk_i, srst_i, hsel, hwrite, gie, ioclk, pdn, wdt, hrdy, hresp, wake, asleep;
    logic [31:0] haddr, hwdata, hrdata, q;
    logic [1:0] htrans;
    logic [2:0] ack, irq, pins;
    int failures, samples_checked;
    epi_pin_src SRC (.clk_i(clk_i), .pin_o(pins));
    epi_ext_irq #(.STARTUP_CYCLES(SU)) DUT (.clk_i(clk_i), .srst_i(srst_i), .hsel_i(hsel), .haddr_i(haddr),
        .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hrdy),
        .hrdata_o(hrdata), .hreadyout_o(hrdy), .hresp_o(hresp), .ext_request_zero_i(pins[0]),
        .ext_request_one_i(pins[1]), .ext_request_two_i(pins[2]), .global_ie_i(gie), .io_clk_run_i(ioclk),
        .power_down_i(pdn), .wdt_tick_i(wdt), .vector_ack_i(ack), .irq_req_o(irq), .wake_o(wake),
        .asleep_o(asleep));
    ////////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            failures++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : cyc
    // Address phase held until hready, then data phase until hready
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_i);
        hsel <= 1'b1;
        haddr <= {20'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge clk_i); while (hrdy !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        do @(posedge clk_i); while (hrdy !== 1'b1);
        q = hrdata;
    endtask : bus
    task automatic pulse_ack(input logic [2:0] v);
        @(posedge clk_i);
        ack <= v;
        @(posedge clk_i);
        ack <= 3'h0;
    endtask : pulse_ack
    task automatic t_reset;
        logic [11:0] ofs [5];
        ofs = '{12'h000, 12'h004, 12'h008, 12'h00C, 12'h010};
        bus(1'b1, 12'h010, 32'h0000_00FF);
        foreach (ofs[i]) begin
            bus(1'b0, ofs[i], 32'h0);
            chk("reset reg", 32'h0, q);
        end
        chk("hresp", 32'h0, {31'h0, hresp});
        $display("t_reset done");
    endtask : t_reset
    task automatic t_edge1;
        logic [1:0] codes [3];
        codes = '{SENSE_ANY, SENSE_FALL, SENSE_RISE};
        bus(1'b1, OFS_EXT_IRQ_ENABLE, 32'h0000_0080);
        foreach (codes[i]) begin
            bus(1'b1, OFS_CPU_CONTROL, {28'h0, codes[i], 2'h0});
            bus(1'b1, OFS_EXT_IRQ_FLAGS, 32'h0000_00E0);
            SRC.set_pin(1, 1'b0);
            cyc(6);
            chk("irq fall", {29'h0, codes[i] != SENSE_RISE, 2'h0} >> 1, {29'h0, irq});
            bus(1'b0, OFS_EXT_IRQ_FLAGS, 32'h0);
            chk("flag fall", (codes[i] != SENSE_RISE) ? 32'h0000_0080 : 32'h0, q);
            bus(1'b1, OFS_EXT_IRQ_FLAGS, 32'h0000_0080);
            SRC.set_pin(1, 1'b1);
            cyc(6);
            bus(1'b0, OFS_EXT_IRQ_FLAGS, 32'h0);
            chk("flag rise", (codes[i] != SENSE_FALL) ? 32'h0000_0080 : 32'h0, q);
            pulse_ack(3'h2);
            bus(1'b0, OFS_EXT_IRQ_FLAGS, 32'h0);
            chk("flag ack", 32'h0, q);
        end
        $display("t_edge1 done");
    endtask : t_edge1
    task automatic t_edge0;
        bus(1'b1, OFS_CPU_CONTROL, {30'h0, SENSE_RISE});
        bus(1'b1, OFS_EXT_IRQ_ENABLE, 32'h0000_0040);
        ioclk <= 1'b0;
        SRC.hold_low(0, 3);
        cyc(6);
        bus(1'b0, OFS_EXT_IRQ_FLAGS, 32'h0);
        chk("no clock", 32'h0, q);
        ioclk <= 1'b1;
        gie <= 1'b0;
        SRC.hold_low(0, 3);
        cyc(6);
        chk("gie off", 32'h0, {29'h0, irq});
        bus(1'b0, OFS_EXT_IRQ_FLAGS, 32'h0);
        chk("flag0", 32'h0000_0040, q);
        gie <= 1'b1;
        cyc(3);
        chk("gie on", 32'h1, {29'h0, irq});
        bus(1'b1, OFS_EXT_IRQ_FLAGS, 32'h0000_0040);
        cyc(3);
        chk("w1c", 32'h0, {29'h0, irq});
        $display("t_edge0 done");
    endtask : t_edge0
    task automatic t_level;
        bus(1'b1, OFS_CPU_CONTROL, 32'h0);
        fork
            SRC.hold_low(0, 30);
            cyc(20);
        join_any
        chk("level irq", 32'h1, {29'h0, irq});
        bus(1'b0, OFS_EXT_IRQ_FLAGS, 32'h0);
        chk("level flag", 32'h0, q);
        cyc(12);
        chk("level off", 32'h0, {29'h0, irq});
        $display("t_level done");
    endtask : t_level
    // Polarity change in the safe order: disable, change, clear, enable
    task automatic t_two;
        for (int p = 0; p < 2; p++) begin
            bus(1'b1, OFS_EXT_IRQ_ENABLE, 32'h0);
            bus(1'b1, OFS_CPU_CONTROL_STATUS, p ? 32'h0000_0040 : 32'h0);
            bus(1'b1, OFS_EXT_IRQ_FLAGS, 32'h0000_0020);
            bus(1'b1, OFS_EXT_IRQ_ENABLE, 32'h0000_0020);
            SRC.set_pin(2, p[0]);
            cyc(6);
            chk("irq two", 32'h4, {29'h0, irq});
            bus(1'b0, OFS_EXT_IRQ_FLAGS, 32'h0);
            chk("flag two", 32'h0000_0020, q);
        end
        pulse_ack(3'h4);
        cyc(3);
        chk("ack two", 32'h0, {29'h0, irq});
        $display("t_two done");
    endtask : t_two
    task automatic t_sleep;
        int i;
        bus(1'b1, OFS_EXT_IRQ_ENABLE, 32'h0000_0040);
        pdn <= 1'b1;
        @(posedge clk_i);
        pdn <= 1'b0;
        cyc(2);
        chk("asleep", 32'h1, {31'h0, asleep});
        SRC.set_pin(0, 1'b0);
        cyc(4);
        chk("no req asleep", 32'h0, {29'h0, irq});
        repeat (2) begin
            @(posedge clk_i);
            wdt <= 1'b1;
            @(posedge clk_i);
            wdt <= 1'b0;
            repeat (3) @(posedge clk_i);
        end
        for (i = 0; i < SU + 20 && wake !== 1'b1; i++) @(posedge clk_i);
        chk("wake", 32'h1, {31'h0, i < SU + 20});
        cyc(3);
        chk("awake irq", 32'h1, {29'h0, irq});
        bus(1'b0, OFS_EXT_IRQ_FLAGS, 32'h0);
        chk("flag sleep", 32'h0000_0020, q);
        SRC.set_pin(0, 1'b1);
        $display("t_sleep done");
    endtask : t_sleep
    ////////////////////////////////////////////////////////////////
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : end_of_test
    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end
    // Whole run is a few hundred cycles
    initial begin
        repeat (20000) @(posedge clk_i);
        failures++;
        end_of_test();
    end
    initial begin
        failures = 0;
        samples_checked = 0;
        srst_i = 1'b1;
        {hsel, hwrite, htrans, haddr, hwdata} = '0;
        {gie, ioclk, pdn, wdt, ack} = 7'h60;
        repeat (2) @(posedge clk_i);
        srst_i <= 1'b0;
        t_reset();
        t_edge1();
        t_edge0();
        t_level();
        t_two();
        t_sleep();
        end_of_test();
    end
endmodule : tb_top
